// File: design/lfb_params.svh
// register offsets, field positions, reset values and sizes of the block
`ifndef LFB_PARAMS_SVH
`define LFB_PARAMS_SVH

// ************************************************************
// register map
// ************************************************************
`define LCM_OFFSET 5'h0F
`define BUF_FIRST 5'h10
`define BUF_LAST 5'h1E

// ************************************************************
// link control mirror fields
// ************************************************************
`define CNT_LSB 2
`define CNT_MSB 5
`define DECLINE_BIT 1
`define TRIGGER_BIT 0

// ************************************************************
// reset values and sizes
// ************************************************************
`define RESET_OCTET 8'h00
`define RESET_COUNT 4'h0
`define BUF_OCTETS 15
`define TX_FIFO_DEPTH 32
`define OCTET_WIDTH 8

`endif

// File: design/lfb_pkg.sv
// types shared by the frame buffer register block
package lfb_pkg;

  // ************************************************************
  // types
  // ************************************************************
  typedef logic [4:0] reg_addr_t;
  typedef logic [7:0] octet_t;
  typedef logic [3:0] octet_idx_t;

  // transmit streaming engine
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } send_state_t;

endpackage : lfb_pkg

// File: design/link_frame_buffer_regs.sv
// link control mirror register and fifteen-octet frame buffer
// ************************************************************
// Overview of operation
// - count valid only while frame ready
// - ready count read gives received octets
// - count write sets response octet count
// - count readback stays the received count
// - trigger sends once first octet written
// - control mirror sits at offset 0x0F
// - fifteen octet buffer at 0x10..0x1E
// - reset clears mirror and buffer bits
// ************************************************************
`timescale 1ns/1ps
`include "lfb_params.svh"

module link_frame_buffer_regs import lfb_pkg::*; #(
  parameter int OCTETS = `BUF_OCTETS,
  parameter int FIFO_DEPTH = `TX_FIFO_DEPTH
) (
  input wire logic CORE_CLK, // core clock, 20 MHz
  input wire logic RESET, // synchronous reset, active high
  input wire logic [4:0] REG_ADDR, // register offset from SPI unit
  input wire logic REG_WR, // one-cycle register write strobe
  input wire logic REG_RD, // one-cycle register read strobe
  input wire logic [7:0] REG_WDATA, // register write data
  output logic [7:0] REG_RDATA, // read data, one cycle after REG_RD
  input wire logic RX_FRAME_READY, // received frame available
  input wire logic [3:0] RX_OCTET_COUNT, // octets in received frame
  input wire logic RX_WR, // receiver stores an octet
  input wire logic [3:0] RX_INDEX, // buffer slot of received octet
  input wire logic [7:0] RX_DATA, // received octet
  output logic [3:0] TX_OCTET_COUNT, // octets to send in response
  output logic TX_START, // one-cycle pulse, response launched
  output logic TX_DECLINE, // one-cycle pulse, response declined
  output logic TX_BUSY, // buffer being streamed out
  output logic [7:0] TX_DATA, // response octet to the UART
  output logic TX_VALID, // TX_DATA holds an octet
  input wire logic TX_READY // UART takes TX_DATA
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  // true for any offset inside the frame buffer window
  function automatic logic buf_hit(input reg_addr_t addr);
    buf_hit = (addr >= `BUF_FIRST) && (addr <= `BUF_LAST);
  endfunction : buf_hit

  // buffer slot addressed by a register offset
  function automatic octet_idx_t buf_index(input reg_addr_t addr);
    reg_addr_t diff;
    diff = addr - `BUF_FIRST;
    buf_index = diff[3:0];
  endfunction : buf_index

  octet_t octet [OCTETS];
  logic ctl_wr;
  logic host_buf_wr;
  logic first_written;
  logic send_armed;
  logic launch;
  logic trig_req;
  logic decline_req;
  logic first_wr;
  send_state_t state;
  octet_idx_t send_idx;
  octet_idx_t send_len;
  logic push_valid;
  logic push_ready;
  logic fifo_valid;
  octet_t fifo_data;

  // ************************************************************
  // write decode
  // ************************************************************
  // buffer writes outside a ready frame are dropped silently
  assign ctl_wr = REG_WR && (REG_ADDR == `LCM_OFFSET);
  assign host_buf_wr = REG_WR && buf_hit(REG_ADDR) && RX_FRAME_READY;
  assign trig_req = ctl_wr && REG_WDATA[`TRIGGER_BIT];
  assign decline_req = ctl_wr && REG_WDATA[`DECLINE_BIT];
  assign first_wr = host_buf_wr && (buf_index(REG_ADDR) == '0);

  // ************************************************************
  // frame buffer storage
  // ************************************************************
  // the receiver wins a collision: it fills the buffer only while no
  // frame is presented to the host, so a clash means a host mistake
  for (genvar i = 0; i < OCTETS; i++) begin : g_octet
    always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
        octet[i] <= `RESET_OCTET;
      end else if (RX_WR && (RX_INDEX == octet_idx_t'(i))) begin
        octet[i] <= RX_DATA;
      end else if (host_buf_wr && (buf_index(REG_ADDR) == octet_idx_t'(i)))
      begin
        octet[i] <= REG_WDATA;
      end
    end
  end

  // ************************************************************
  // link control mirror
  // ************************************************************
  // the written count only steers the transmitter; reads never see it
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      TX_OCTET_COUNT <= `RESET_COUNT;
    end else if (ctl_wr) begin
      TX_OCTET_COUNT <= REG_WDATA[`CNT_MSB:`CNT_LSB];
    end
  end

  // first buffer octet seen; a fresh write wins over the launch clear
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      first_written <= 1'b0;
    end else if (first_wr) begin
      first_written <= 1'b1;
    end else if (launch || decline_req) begin
      first_written <= 1'b0;
    end
  end

  // deferred send: the trigger waits for the first octet, decline wins
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      send_armed <= 1'b0;
    end else if (decline_req) begin
      send_armed <= 1'b0;
    end else if (trig_req) begin
      send_armed <= 1'b1;
    end else if (launch) begin
      send_armed <= 1'b0;
    end
  end

  assign launch = send_armed && first_written && (state == ST_IDLE);

  // event pulses to the rest of the link unit
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      TX_START <= 1'b0;
      TX_DECLINE <= 1'b0;
    end else begin
      TX_START <= launch;
      TX_DECLINE <= decline_req;
    end
  end

  // ************************************************************
  // response streaming
  // ************************************************************
  // octets leave in slot order; the fifo stalls us when the UART lags
  assign push_valid = (state == ST_SEND) && (send_idx != send_len);

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state <= ST_IDLE;
      send_idx <= '0;
      send_len <= '0;
      TX_BUSY <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (launch) begin
            state <= ST_SEND;
            send_idx <= '0;
            send_len <= TX_OCTET_COUNT;
            TX_BUSY <= 1'b1;
          end
        end
        ST_SEND: begin
          if (send_idx == send_len) begin
            state <= ST_IDLE;
            TX_BUSY <= 1'b0;
          end else if (push_ready) begin
            send_idx <= send_idx + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          TX_BUSY <= 1'b0;
        end
      endcase
    end
  end

  // count above the buffer size is clamped to the last slot
  octet_t push_data;
  assign push_data = (send_idx < octet_idx_t'(OCTETS)) ?
                     octet[send_idx] : octet[OCTETS-1];

  octet_fifo #(
    .WIDTH(`OCTET_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(CORE_CLK),
    .reset(RESET),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(push_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(TX_READY)
  );

  assign TX_DATA = fifo_data;
  assign TX_VALID = fifo_valid;

  // ************************************************************
  // read path
  // ************************************************************
  // count is zero unless a frame is ready, so stale values never leak;
  // trigger and decline bits are write-only and read zero
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      REG_RDATA <= `RESET_OCTET;
    end else if (REG_RD) begin
      if (REG_ADDR == `LCM_OFFSET) begin
        REG_RDATA <= '0;
        if (RX_FRAME_READY) begin
          REG_RDATA[`CNT_MSB:`CNT_LSB] <= RX_OCTET_COUNT;
        end
      end else if (buf_hit(REG_ADDR) && RX_FRAME_READY) begin
        REG_RDATA <= octet[buf_index(REG_ADDR)];
      end else begin
        REG_RDATA <= '0;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  count_read_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    REG_RD && (REG_ADDR == `LCM_OFFSET) && RX_FRAME_READY
    |=> REG_RDATA[`CNT_MSB:`CNT_LSB] == $past(RX_OCTET_COUNT))
  else $error("count read does not match received octets");

  count_hidden_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    REG_RD && (REG_ADDR == `LCM_OFFSET) && !RX_FRAME_READY
    |=> REG_RDATA == 8'h00)
  else $error("count visible without a ready frame");

  tx_count_set_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    ctl_wr |=> TX_OCTET_COUNT == $past(REG_WDATA[`CNT_MSB:`CNT_LSB]))
  else $error("written count not applied to response");

  count_readback_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    ctl_wr ##[1:2] (REG_RD && (REG_ADDR == `LCM_OFFSET) && RX_FRAME_READY)
    |=> REG_RDATA[`CNT_MSB:`CNT_LSB] == $past(RX_OCTET_COUNT))
  else $error("readback returned the written count");

  send_gated_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    TX_START |-> $past(first_written) && $past(send_armed))
  else $error("response launched before first octet");

  send_delay_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    trig_req && !decline_req && first_written && (state == ST_IDLE)
    |=> ##1 TX_START)
  else $error("armed trigger did not launch");

  mirror_bits_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    REG_RD && (REG_ADDR == `LCM_OFFSET)
    |=> (REG_RDATA[7:6] == 2'b00) && (REG_RDATA[1:0] == 2'b00))
  else $error("mirror reserved or write-only bits read nonzero");

  buf_store_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    host_buf_wr && !RX_WR
    |=> octet[$past(buf_index(REG_ADDR))] == $past(REG_WDATA))
  else $error("buffer octet not stored");

  buf_locked_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    REG_RD && buf_hit(REG_ADDR) && !RX_FRAME_READY |=> REG_RDATA == 8'h00)
  else $error("locked buffer returned data");

  reset_clear_a: assert property (
    @(posedge CORE_CLK)
    $past(RESET) && RESET
    |-> (TX_OCTET_COUNT == 4'h0) && (REG_RDATA == 8'h00) && !TX_START)
  else $error("state not cleared by reset");

  decline_drop_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    decline_req |=> ##1 !TX_START)
  else $error("declined response was launched");

  busy_on_start_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    TX_START |-> TX_BUSY)
  else $error("launch without streaming");

endmodule : link_frame_buffer_regs

// File: design/octet_fifo.sv
// first-in first-out buffer with registered read data
`timescale 1ns/1ps

module octet_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic in_valid, // producer offers a word
  input wire logic [WIDTH-1:0] in_data, // word offered
  output logic in_ready, // room for a word
  output logic out_valid, // out_data holds a word
  output logic [WIDTH-1:0] out_data, // registered head word
  input wire logic out_ready // consumer takes out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] used;
  logic take;
  logic give;

  // ************************************************************
  // handshakes
  // ************************************************************
  // give refills the output register whenever it is empty or drained
  assign in_ready = (used != (AW+1)'(DEPTH));
  assign take = in_valid && in_ready;
  assign give = (used != '0) && (!out_valid || out_ready);

  // storage carries no reset: only words behind the pointers are read
  always_ff @(posedge clk) begin
    if (take) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // write pointer, wraps at any depth
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
    end else if (take) begin
      wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_ptr <= '0;
    end else if (give) begin
      rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
  end

  // fill level
  always_ff @(posedge clk) begin
    if (reset) begin
      used <= '0;
    end else if (take && !give) begin
      used <= used + 1'b1;
    end else if (give && !take) begin
      used <= used - 1'b1;
    end
  end

  // output register
  always_ff @(posedge clk) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (give) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule : octet_fifo

// File: tb/testbench.sv
// self-checking bench for the frame buffer register block
`timescale 1ns/1ps

module testbench import lfb_pkg::*; ;
  logic clk, reset, reg_wr, reg_rd, rx_ready, rx_wr, tx_ready, hold;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_data, tx_data, seen;
  logic [3:0] rx_count, rx_index, tx_count;
  logic tx_start, tx_decline, tx_busy, tx_valid;
  int num_errors = 0;
  int checked = 0;
  int n_start = 0;
  int n_decline = 0;
  int k;
  typedef struct {reg_addr_t a; octet_t w; octet_t e;} row_t;
  // address, written value, value read back (received count is 9)
  row_t rows [6] = '{'{5'h10, 8'hA5, 8'hA5}, '{5'h1E, 8'h3C, 8'h3C},
    '{5'h17, 8'hFF, 8'hFF}, '{5'h0F, 8'h2A, 8'h24},
    '{5'h05, 8'h77, 8'h00}, '{5'h1F, 8'h77, 8'h00}};

  link_frame_buffer_regs link_frame_buffer_regs_i (.CORE_CLK(clk),
    .RESET(reset), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .RX_FRAME_READY(rx_ready), .RX_OCTET_COUNT(rx_count), .RX_WR(rx_wr),
    .RX_INDEX(rx_index), .RX_DATA(rx_data), .TX_OCTET_COUNT(tx_count),
    .TX_START(tx_start), .TX_DECLINE(tx_decline), .TX_BUSY(tx_busy),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready));

  tx_sink tx_sink_i (.clk(clk), .reset(reset), .hold(hold),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic close_out();
    $display("errors=%0d checked=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic chk(string name, logic [7:0] s, logic [7:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, e, s);
    end
  endtask : chk

  task automatic cycles(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  // strobes are spaced a cycle apart so no signal changes twice at once
  task automatic wr(logic [4:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cycles(1);
    reg_wr = 1'b0;
    cycles(1);
  endtask : wr

  task automatic rd(logic [4:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    cycles(1);
    reg_rd = 1'b0;
    cycles(1);
    seen = reg_rdata;
  endtask : rd

  task automatic wait_start(int t);
    for (int i = 0; i < 60 && n_start < t; i++) cycles(1);
    chk("launches", 8'(n_start), 8'(t));
  endtask : wait_start

  // waits for n octets, then makes sure no extra octet follows
  task automatic drain(int n);
    for (int i = 0; i < 300 && tx_sink_i.got.size() < n; i++) cycles(1);
    cycles(10);
    chk("octets sent", 8'(tx_sink_i.got.size()), 8'(n));
  endtask : drain

  // ************************************************************
  // clock, pulse counters, watchdog
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // launch and decline are one-cycle pulses, so count them at each edge
  always @(posedge clk) begin
    if (tx_start === 1'b1) n_start <= n_start + 1;
    if (tx_decline === 1'b1) n_decline <= n_decline + 1;
  end

  // the sequence needs about 400 cycles; allow fifty times that
  initial begin
    #(20000 * 50);
    num_errors++;
    close_out();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {reset, hold, rx_ready} = 3'b101;
    {reg_wr, reg_rd, rx_wr} = 3'b000;
    {reg_addr, reg_wdata, rx_data} = '0;
    {rx_count, rx_index} = '0;
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    cycles(1);
    chk("tx count", tx_count, 4'h0);
    rd(5'h0F);
    chk("mirror", seen, 8'h00);
    for (k = 0; k < 15; k++) begin
      rd(5'h10 + 5'(k));
      chk("octet", seen, 8'h00);
    end
    rx_count = 4'h9;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk("row", seen, rows[i].e);
    end
    chk("tx count", tx_count, 4'hA);
    chk("declines", 8'(n_decline), 8'h01);
    // receiver store, slot 15 must be dropped
    {rx_index, rx_data, rx_wr} = {4'h3, 8'h5A, 1'b1};
    cycles(1);
    {rx_index, rx_data} = {4'hF, 8'h99};
    cycles(1);
    rx_wr = 1'b0;
    rd(5'h13);
    chk("rx store", seen, 8'h5A);
    rd(5'h1E);
    chk("rx drop", seen, 8'h3C);
    // no frame ready: buffer locked, count meaningless
    rx_ready = 1'b0;
    wr(5'h10, 8'h11);
    rd(5'h10);
    chk("locked", seen, 8'h00);
    rd(5'h0F);
    chk("idle count", seen, 8'h00);
    rx_ready = 1'b1;
    rd(5'h10);
    chk("kept", seen, 8'hA5);
    // deferred send: trigger first, slot 0 written last
    wr(5'h0F, 8'h11);
    cycles(10);
    chk("early launch", 8'(n_start), 8'h00);
    for (k = 14; k >= 0; k--) wr(5'h10 + 5'(k), 8'h40 + 8'(k));
    wait_start(1);
    drain(4);
    chk("idle", tx_busy, 1'b0);
    for (k = 0; k < 4; k++) chk("sent", tx_sink_i.got[k], 8'h40 + 8'(k));
    // decline in the same write as the trigger wins
    wr(5'h10, 8'h40);
    wr(5'h0F, 8'h13);
    cycles(10);
    chk("declined", 8'(n_start), 8'h01);
    chk("declines", 8'(n_decline), 8'h02);
    // three full frames against a stalled link overfill the fifo
    hold = 1'b1;
    for (k = 2; k < 5; k++) begin
      wr(5'h0F, 8'h3D);
      wr(5'h10, 8'h40);
      wait_start(k);
    end
    cycles(40);
    chk("busy when full", tx_busy, 1'b1);
    chk("stalled", 8'(tx_sink_i.got.size()), 8'h04);
    hold = 1'b0;
    drain(49);
    for (k = 4; k < 49; k++) begin
      chk("sent", tx_sink_i.got[k], 8'h40 + 8'((k - 4) % 15));
    end
    // slot 0 first, then a count-zero trigger: launch with nothing sent
    wr(5'h10, 8'h40);
    wr(5'h0F, 8'h01);
    wait_start(5);
    drain(49);
    chk("idle", tx_busy, 1'b0);
    // reset again in mid-run
    reset = 1'b1;
    cycles(2);
    reset = 1'b0;
    cycles(1);
    rd(5'h10);
    chk("octet", seen, 8'h00);
    chk("tx count", tx_count, 4'h0);
    close_out();
  end
endmodule : testbench

// File: tb/tx_sink.sv
// uart-side consumer model that drains response octets
`timescale 1ns/1ps

module tx_sink (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic hold, // stall the link completely
  input wire logic [7:0] tx_data, // offered octet
  input wire logic tx_valid, // octet offered
  output logic tx_ready // octet taken
);
  logic [7:0] got [$];

  initial tx_ready = 1'b0;

  // ready only every other cycle, so the fifo always sees back-pressure
  always @(posedge clk) begin
    if (reset) begin
      tx_ready <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) got.push_back(tx_data);
      tx_ready <= !hold && !tx_ready;
    end
  end
endmodule : tx_sink
